// *** src/mon_align_map.vh ***
// Constants for the receive channel monitor and store align control.
// Assumes the includer works on one 200 MHz clock, MCLK.
// Behaviour
// R1 - Host writes zero to control bit 7
// R2 - Receive align rise forces half-frame separation
// R3 - Separation already half frame: no action
// R4 - Separation short: realign, data may corrupt
// R5 - Host toggles receive align after clock stable
// R6 - Align held high never realigns again
// R7 - Transmit align rise does the same
// R8 - Host toggles transmit align after clock stable
// R9 - Five-bit field selects the monitored channel
// R10 - First received bit lands in bit 7
// R11 - Processor and hardware signaling run together
// R12 - Host programs selector with timeslot number
// R13 - Monitor byte refreshed once per frame, whole
`ifndef MON_ALIGN_MAP_VH
`define MON_ALIGN_MAP_VH
`define CTRL_ADDR        8'haa
`define MON_ADDR         8'hab
`define CTRL_RESET       8'h00
`define MON_RESET        8'h00
`define CTRL_RSVD_BIT    7
`define CTRL_RX_ALIGN    6
`define CTRL_TX_ALIGN    5
`define CTRL_SEL_MSB     4
`define CTRL_SEL_LSB     0
`define UNMAPPED_DATA    8'h00
`define BITS_PER_FRAME   256
`define LAST_BIT_IN_SLOT 3'h7
`endif

// *** src/rx_ds0_monitor_estore_align.v ***
// Control register with store align commands and channel monitor.
// Assumes host port and receive bit stream are synchronous to MCLK.
`include "mon_align_map.vh"

// Edge detect and gate for one elastic store align command
module store_align_pulse (
	input  wire clk,
	input  wire rst,
	input  wire cmd,
	input  wire sep_half,
	output reg  pulse
);

	reg  cmd_d_r;
	reg  pulse_nxt;
	wire rise;

	// Only a zero-to-one edge counts, so a held one is ignored
	assign rise = cmd & ~cmd_d_r; // R6

	// Wide separation leaves the store untouched
	always @* begin
		pulse_nxt = 1'b0;
		if (rise) begin
			pulse_nxt = ~sep_half; // R2 R3 R4
		end
	end

	// Delayed command resets low like the command, no false edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_d_r <= 1'b0;
			pulse   <= 1'b0;
		end else begin
			cmd_d_r <= cmd;
			pulse   <= pulse_nxt;
		end
	end

endmodule // store_align_pulse

module rx_ds0_monitor_estore_align (
	input  wire       MCLK,
	input  wire       RST,
	input  wire       CS,
	input  wire       WR,
	input  wire [7:0] ADDR,
	input  wire [7:0] WR_DATA,
	output reg  [7:0] RD_DATA,
	input  wire       RX_BIT_EN,
	input  wire       RX_FRAME_START,
	input  wire       RX_DATA,
	input  wire       RX_SEP_HALF,
	input  wire       TX_SEP_HALF,
	output reg        RX_ALIGN,
	output reg        TX_ALIGN,
	output wire       SIG_CPU_EN,
	output wire       SIG_HW_EN
);

	reg  [6:0] ctrl_r;
	reg  [7:0] mon_r;
	reg  [7:0] shift_r;
	reg  [7:0] shift_nxt;
	reg  [7:0] bitcnt_r;
	reg  [6:0] ctrl_nxt;
	reg  [7:0] bitcnt_nxt;
	reg  [7:0] mon_nxt;
	reg  [7:0] rd_nxt;
	wire       rx_pulse;
	wire       tx_pulse;
	wire       wr_ctrl;
	wire [4:0] sel;
	wire [7:0] bitpos;
	wire       in_slot;

	assign wr_ctrl = CS & WR & (ADDR == `CTRL_ADDR);
	assign sel     = ctrl_r[`CTRL_SEL_MSB:`CTRL_SEL_LSB]; // R9 R12
	// Frame start marks bit 0 even if the counter drifted
	assign bitpos  = RX_FRAME_START ? 8'h00 : bitcnt_r;
	assign in_slot = RX_BIT_EN & (bitpos[7:3] == sel);

	// Reserved bit 7 is not stored; it always reads zero
	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = WR_DATA[6:0]; // R1
		end
	end

	// Control register
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_r <= 7'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Receive store align; pulse only when separation is short
	store_align_pulse u_rx_align (
		.clk      (MCLK),
		.rst      (RST),
		.cmd      (ctrl_r[`CTRL_RX_ALIGN]),
		.sep_half (RX_SEP_HALF),
		.pulse    (rx_pulse)
	); // R2 R3 R4 R6

	// Transmit store gets the same treatment
	store_align_pulse u_tx_align (
		.clk      (MCLK),
		.rst      (RST),
		.cmd      (ctrl_r[`CTRL_TX_ALIGN]),
		.sep_half (TX_SEP_HALF),
		.pulse    (tx_pulse)
	); // R7

	// Pulses come straight from the per-store flip-flops
	always @* begin
		RX_ALIGN = rx_pulse;
		TX_ALIGN = tx_pulse;
	end

	// Next bit position; the 8-bit counter wraps with the frame
	always @* begin
		bitcnt_nxt = bitcnt_r;
		if (RX_BIT_EN) begin
			bitcnt_nxt = bitpos + 8'h01;
		end
	end

	// Bit position within the 256-bit frame
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			bitcnt_r <= 8'h00;
		end else begin
			bitcnt_r <= bitcnt_nxt;
		end
	end

	// First received bit shifts up to the MSB
	always @* begin
		shift_nxt = shift_r;
		mon_nxt   = mon_r;
		if (in_slot) begin
			shift_nxt = {shift_r[6:0], RX_DATA}; // R10
			if (bitpos[2:0] == `LAST_BIT_IN_SLOT) begin
				mon_nxt = {shift_r[6:0], RX_DATA}; // R13
			end
		end
	end

	// Loading only after the eighth bit keeps reads consistent
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			shift_r <= 8'h00;
			mon_r   <= `MON_RESET;
		end else begin
			shift_r <= shift_nxt;
			mon_r   <= mon_nxt;
		end
	end

	// Read mux; unmapped addresses read zero
	always @* begin
		rd_nxt = `UNMAPPED_DATA;
		case (ADDR)
			`CTRL_ADDR: begin
				rd_nxt[6:0] = ctrl_r;
				rd_nxt[`CTRL_RSVD_BIT] = 1'b0; // R1
			end
			`MON_ADDR: begin
				rd_nxt = mon_r;
			end
			default: begin
				rd_nxt = `UNMAPPED_DATA;
			end
		endcase
	end

	// Registered read data follows ADDR one edge later
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			RD_DATA <= `UNMAPPED_DATA;
		end else begin
			RD_DATA <= rd_nxt;
		end
	end

	// Neither signaling path gates the other
	assign SIG_CPU_EN = 1'b1; // R11
	assign SIG_HW_EN  = 1'b1; // R11

endmodule // rx_ds0_monitor_estore_align

// *** testbench/mon_asserts.sv ***
// Align pulse, read-back and signaling enable checks.
// Bound to the top module by tb_top; sees its ports only.
module mon_chk(
	input logic       MCLK,
	input logic       RST,
	input logic       CS,
	input logic       WR,
	input logic       RX_SEP_HALF,
	input logic       TX_SEP_HALF,
	input logic       RX_ALIGN,
	input logic       TX_ALIGN,
	input logic       SIG_CPU_EN,
	input logic       SIG_HW_EN,
	input logic [7:0] ADDR,
	input logic [7:0] WR_DATA,
	input logic [7:0] RD_DATA
);
	timeunit 1ns; timeprecision 1ns;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// Align bits of a control write
	wire [1:0] w = {2{CS && WR && ADDR == 8'haa}} & WR_DATA[6:5];
	sequence s_r; w[1] ##1 RX_SEP_HALF; endsequence
	property p_rs; s_r |=> !RX_ALIGN; endproperty
	a_rs: assert property (p_rs) else $error("rx gap");
	property p_rc; RX_ALIGN |-> $past(w[1], 2) ##1 !RX_ALIGN; endproperty
	a_rc: assert property (p_rc) else $error("rx align");
	property p_tc; TX_ALIGN |-> $past(w[0], 2) ##1 !TX_ALIGN; endproperty
	a_tc: assert property (p_tc) else $error("tx align");
	sequence s_t; w[0] ##1 TX_SEP_HALF; endsequence
	property p_ts; s_t |=> !TX_ALIGN; endproperty
	a_ts: assert property (p_ts) else $error("tx gap");
	property p_rl; RX_ALIGN |-> !$past(RX_SEP_HALF); endproperty
	a_rl: assert property (p_rl) else $error("rx wide");
	property p_rv; ADDR == 8'haa |=> !RD_DATA[7]; endproperty
	a_rv: assert property (p_rv) else $error("bit 7 set");
	property p_sg; SIG_CPU_EN && SIG_HW_EN; endproperty
	a_sg: assert property (p_sg) else $error("sig off");
endmodule // mon_chk

// *** testbench/host_model.sv ***
// Host on the control port.
// Drives at the falling edge of MCLK.
module host_model(
	input  logic       MCLK,
	output logic       CS,
	output logic       WR,
	output logic [7:0] ADDR,
	output logic [7:0] WR_DATA
);
	timeunit 1ns; timeprecision 1ns;
	// Idle bus before reset ends
	initial {CS, WR, ADDR, WR_DATA} = 18'h0;
	// One write; bit 7 kept clear
	task put(input logic [7:0] v);
		@(negedge MCLK) {CS, WR, ADDR} = {2'h3, 8'haa};
		WR_DATA = {1'b0, v[6:0]};
		@(negedge MCLK) {CS, WR, WR_DATA} = {2'h0, ~WR_DATA};
	endtask
	task look(input logic [7:0] a);
		@(negedge MCLK) ADDR = a;
	endtask
endmodule // host_model

// *** testbench/tb_top.sv ***
// Align and monitor scenarios.
// Needs the design, host model and checker.
module tb_top;
	timeunit 1ns; timeprecision 1ns;
	logic       MCLK = 0, RST = 1, RX_BIT_EN, RX_FRAME_START;
	logic       RX_DATA, RX_SEP_HALF, TX_SEP_HALF;
	logic       CS, WR, RX_ALIGN, TX_ALIGN, SIG_CPU_EN, SIG_HW_EN;
	logic [7:0] ADDR, WR_DATA, RD_DATA;
	int         n_errors = 0, n_checks = 0, n_ra = 0, n_ta = 0;
	host_model u_host_model(
		.MCLK    (MCLK),
		.CS      (CS),
		.WR      (WR),
		.ADDR    (ADDR),
		.WR_DATA (WR_DATA)
	);
	rx_ds0_monitor_estore_align u_rx_ds0_monitor_estore_align(
		.MCLK           (MCLK),
		.RST            (RST),
		.CS             (CS),
		.WR             (WR),
		.ADDR           (ADDR),
		.WR_DATA        (WR_DATA),
		.RD_DATA        (RD_DATA),
		.RX_BIT_EN      (RX_BIT_EN),
		.RX_FRAME_START (RX_FRAME_START),
		.RX_DATA        (RX_DATA),
		.RX_SEP_HALF    (RX_SEP_HALF),
		.TX_SEP_HALF    (TX_SEP_HALF),
		.RX_ALIGN       (RX_ALIGN),
		.TX_ALIGN       (TX_ALIGN),
		.SIG_CPU_EN     (SIG_CPU_EN),
		.SIG_HW_EN      (SIG_HW_EN)
	);
	initial forever #2.5 MCLK = ~MCLK;
	// Pulses last one cycle; tally mid-cycle where they are settled
	always @(negedge MCLK) n_ra += RX_ALIGN;
	always @(negedge MCLK) n_ta += TX_ALIGN;
	task chk(input logic [7:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t %h %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Rise, hold, rise over a wide gap, then rise with only the transmit gap short
	task t_al;
		u_host_model.put(8'h60);
		u_host_model.put(8'h60);
		{RX_SEP_HALF, TX_SEP_HALF} = 2'h3;
		u_host_model.put(8'h00);
		u_host_model.put(8'h60);
		// Let the write settle before the gaps change
		repeat (2) @(negedge MCLK);
		{RX_SEP_HALF, TX_SEP_HALF} = 2'h2;
		u_host_model.put(8'h00);
		u_host_model.put(8'h60);
		repeat (3) @(negedge MCLK);
		chk(n_ra, 1);
		chk(n_ta, 2);
		chk({6'h00, SIG_CPU_EN, SIG_HW_EN}, 8'h03);
	endtask
	// Slot 2 carries b4, all else ones
	task t_mon;
		u_host_model.put(8'h02);
		u_host_model.look(8'hab);
		for (int i = 0; i < 256; i++) begin
			@(negedge MCLK);
			if (i == 20) chk(RD_DATA, 8'h00);
			{RX_BIT_EN, RX_FRAME_START} = {1'b1, i == 0};
			RX_DATA = i / 8 == 2 ? 8'hb4 >> 7 - i % 8 : 1;
			@(negedge MCLK);
			{RX_BIT_EN, RX_FRAME_START, RX_DATA} = {2'h0, ~RX_DATA};
		end
		repeat (2) @(negedge MCLK);
		chk(RD_DATA, 8'hb4);
		u_host_model.look(8'haa);
		repeat (2) @(negedge MCLK);
		chk(RD_DATA, 8'h02);
	endtask
	initial begin
		{RX_BIT_EN, RX_FRAME_START, RX_DATA} = 3'h0;
		{RX_SEP_HALF, TX_SEP_HALF} = 2'h0;
		repeat (12) @(negedge MCLK);
		RST = 0;
		t_al;
		t_mon;
		close_out;
	end
	initial begin
		#20000;
		n_errors++;
		close_out;
	end
endmodule // tb_top
bind rx_ds0_monitor_estore_align mon_chk u_mon_chk(
	.MCLK        (MCLK),
	.RST         (RST),
	.CS          (CS),
	.WR          (WR),
	.RX_SEP_HALF (RX_SEP_HALF),
	.TX_SEP_HALF (TX_SEP_HALF),
	.RX_ALIGN    (RX_ALIGN),
	.TX_ALIGN    (TX_ALIGN),
	.SIG_CPU_EN  (SIG_CPU_EN),
	.SIG_HW_EN   (SIG_HW_EN),
	.ADDR        (ADDR),
	.WR_DATA     (WR_DATA),
	.RD_DATA     (RD_DATA)
);
